// ---- acic_pkg.sv ----
// package of offsets, field positions, reset values and codes for the aux control block
package acic_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_AUX_CTRL      = 8'h04;
  localparam logic [7:0] ADDR_INT_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_INT_MASK      = 8'h18;
  localparam logic [7:0] ADDR_TICK_DIV      = 8'h1c;
  localparam logic [7:0] AUX_CTRL_RESET     = 8'h00;
  localparam logic [7:0] INT_MASK_RESET     = 8'h00;
  localparam logic [7:0] INT_STATUS_RESET   = 8'h00;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BRG_SEL_BIT    = 7;
  localparam int CT_MODE_LSB    = 4;
  localparam int COS_INT_BIT    = 7;
  localparam int DELTA_LSB      = 4;
  localparam int NUM_INPUTS     = 4;
  localparam int PRESCALE       = 16;
  localparam logic [15:0] TICK_DIV_RESET = 16'h0001;
  // ------------------------------------------------------------
  // counter/timer mode codes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CT_CNT_IN2      = 3'h0,
    CT_CNT_TXA      = 3'h1,
    CT_CNT_TXB      = 3'h2,
    CT_CNT_MCLK16   = 3'h3,
    CT_TMR_IN2      = 3'h4,
    CT_TMR_IN2_16   = 3'h5,
    CT_TMR_MCLK     = 3'h6,
    CT_TMR_MCLK16   = 3'h7
  } acic_ct_mode_t;
endpackage : acic_pkg

// ---- acic_in_sync.sv ----
// synchroniser and change detector for the general-purpose inputs
`timescale 1ns/1ps
module acic_in_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] change_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] chg;
  } acic_sync_st_t;
  acic_sync_st_t st_r;
  acic_sync_st_t st_nxt;

  // two flops, then compare to the last stable level
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = pin_i;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
    st_nxt.chg  = st_r.sync ^ st_r.prev;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o  = st_r.prev;
  assign change_o = st_r.chg;
endmodule // acic_in_sync

// ---- acic_top.sv ----
// aux control register, input change register and counter/timer clock selection
//
// Contract
// - bit 7 picks the baud rate set
// - codes 000-010 count pin 2, tx A, tx B
// - codes 100/101 time pin 2, direct or /16
// - 011 count clk/16; 110/111 time clk, clk/16
// - timer codes give a square wave
// - enabled change flag sets summary status bit 7
// - disabled flag leaves summary bit alone
// - summary drives interrupt only when mask bit 7 set
// - change flags bits 7-4 for inputs 3-0
// - reading change register clears the four flags
// - that read also clears summary bit 7
// - bits 3-0 show current input levels
// - control and change registers share address 4
// - any status and mask pair asserts interrupt low
// - reset clears summary status bit 7; bits 6-0 follow other_status_i
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module acic_top #(
  parameter int NUM_IN = acic_pkg::NUM_INPUTS
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  gp_input_i,
  input  wire logic        chan_a_tx_clock_i,
  input  wire logic        chan_b_tx_clock_i,
  input  wire logic        main_clock_input_i,
  input  wire logic [6:0]  other_status_i,
  output logic             brg_set_sel_o,
  output logic             ct_timer_mode_o,
  output logic             ct_tick_o,
  output logic             ct_square_wave_o,
  output logic             interrupt_out_n_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  aux_ctrl;
    logic [7:0]  int_mask;
    logic        cos_status;
    logic [3:0]  delta;
    logic [15:0] tick_div;
    logic [15:0] div_cnt;
    logic [3:0]  pre_cnt;
    logic [3:0]  pin_seen;
    logic        src_prev;
    logic        tick;
    logic        square;
    logic        timer_mode;
    logic        brg_sel;
    logic        irq_n;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } acic_st_t;
  acic_st_t st_r;
  acic_st_t st_nxt;

  logic [3:0] lvl;
  logic [3:0] chg;

  // ------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------
  acic_in_sync #(
    .WIDTH    (NUM_IN)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (gp_input_i),
    .level_o   (lvl),
    .change_o  (chg)
  );

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  logic          setup;
  logic          access;
  logic          rd_chg;
  logic [2:0]    mode_code;
  logic          src_lvl;
  logic          src_edge;
  logic          pre_div;
  logic          step;
  logic [7:0]    ics_val;
  logic [7:0]    stat_all;

  always_comb begin
    st_nxt    = st_r;
    setup     = psel && !penable;
    access    = psel && penable && st_r.ready;
    rd_chg    = access && !pwrite && (paddr == acic_pkg::ADDR_AUX_CTRL);
    mode_code = st_r.aux_ctrl[acic_pkg::CT_MODE_LSB +: 3];
    src_lvl   = 1'b0;
    pre_div   = 1'b0;
    step      = 1'b0;
    // clock source select for the counter/timer
    case (mode_code)
      acic_pkg::CT_CNT_IN2:    src_lvl = lvl[2];
      acic_pkg::CT_CNT_TXA:    src_lvl = chan_a_tx_clock_i;
      acic_pkg::CT_CNT_TXB:    src_lvl = chan_b_tx_clock_i;
      acic_pkg::CT_CNT_MCLK16: begin
        src_lvl = main_clock_input_i;
        pre_div = 1'b1;
      end
      acic_pkg::CT_TMR_IN2:    src_lvl = lvl[2];
      acic_pkg::CT_TMR_IN2_16: begin
        src_lvl = lvl[2];
        pre_div = 1'b1;
      end
      acic_pkg::CT_TMR_MCLK:   src_lvl = main_clock_input_i;
      default: begin
        src_lvl = main_clock_input_i;
        pre_div = 1'b1;
      end
    endcase
    src_edge        = src_lvl && !st_r.src_prev;
    st_nxt.src_prev = src_lvl;
    // optional divide-by-sixteen prescaler
    if (src_edge) begin
      if (pre_div) begin
        st_nxt.pre_cnt = st_r.pre_cnt + 4'h1;
        step = (st_r.pre_cnt == 4'(acic_pkg::PRESCALE - 1));
      end else begin
        step = 1'b1;
      end
    end
    // divider: counter gives a one-shot tick, timer toggles a square wave
    st_nxt.tick       = 1'b0;
    st_nxt.timer_mode = mode_code[2];
    st_nxt.brg_sel    = st_r.aux_ctrl[acic_pkg::BRG_SEL_BIT];
    if (step) begin
      if (st_r.div_cnt >= st_r.tick_div - 16'h0001) begin
        st_nxt.div_cnt = 16'h0000;
        if (mode_code[2]) begin
          st_nxt.square = !st_r.square;
        end else begin
          st_nxt.tick = 1'b1;
        end
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 16'h0001;
      end
    end
    if (!mode_code[2]) begin
      st_nxt.square = 1'b0;
    end
    // change flags: read clears, a new change in the same cycle wins
    if (rd_chg) begin
      st_nxt.delta = 4'h0;
      st_nxt.cos_status = 1'b0;
    end
    st_nxt.delta = st_nxt.delta | chg;
    if (|(chg & st_r.aux_ctrl[3:0])) begin
      st_nxt.cos_status = 1'b1;
    end
    // interrupt output
    stat_all = {st_nxt.cos_status, other_status_i};
    st_nxt.irq_n = !(|(stat_all & st_r.int_mask));
    // apb slave, no wait states
    st_nxt.ready  = setup;
    st_nxt.slverr = 1'b0;
    // a change flagged during the setup cycle is returned too, since this read clears it
    ics_val = {st_r.delta | chg, lvl};
    if (setup) begin
      st_nxt.rdata = 32'h0000_0000;
      if (paddr == acic_pkg::ADDR_AUX_CTRL) begin
        if (pwrite) begin
          st_nxt.rdata = 32'h0000_0000;
        end else begin
          st_nxt.rdata = {24'h00_0000, ics_val};
        end
      end else if (paddr == acic_pkg::ADDR_INT_STATUS) begin
        st_nxt.rdata = {24'h00_0000, st_r.cos_status, other_status_i};
      end else if (paddr == acic_pkg::ADDR_INT_MASK) begin
        st_nxt.rdata = {24'h00_0000, st_r.int_mask};
      end else if (paddr == acic_pkg::ADDR_TICK_DIV) begin
        st_nxt.rdata = {16'h0000, st_r.tick_div};
      end else begin
        st_nxt.slverr = 1'b1;
      end
    end
    if (access) begin
      if (pwrite) begin
        if (paddr == acic_pkg::ADDR_AUX_CTRL) begin
          st_nxt.aux_ctrl = pwdata[7:0];
        end else if (paddr == acic_pkg::ADDR_INT_MASK) begin
          st_nxt.int_mask = pwdata[7:0];
        end else if (paddr == acic_pkg::ADDR_TICK_DIV) begin
          st_nxt.tick_div = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r            <= '0;
      st_r.aux_ctrl   <= acic_pkg::AUX_CTRL_RESET;
      st_r.int_mask   <= acic_pkg::INT_MASK_RESET;
      st_r.cos_status <= acic_pkg::INT_STATUS_RESET[acic_pkg::COS_INT_BIT];
      st_r.tick_div   <= acic_pkg::TICK_DIV_RESET;
      st_r.irq_n      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs, all registered
  // ------------------------------------------------------------
  assign prdata            = st_r.rdata;
  assign pready            = st_r.ready;
  assign pslverr           = st_r.slverr;
  assign brg_set_sel_o     = st_r.brg_sel;
  assign ct_timer_mode_o   = st_r.timer_mode;
  assign ct_tick_o         = st_r.tick;
  assign ct_square_wave_o  = st_r.square;
  assign interrupt_out_n_o = st_r.irq_n;
endmodule // acic_top

// ---- acic_top_monitor.sv ----
// checker on the aux control block ports
`timescale 1ns/1ps
module acic_top_monitor (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        brg_set_sel_o,
  input wire logic        ct_timer_mode_o,
  input wire logic        ct_square_wave_o,
  input wire logic        interrupt_out_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // completed write to the shared control address
  wire logic wr4 = psel && penable && pready && pwrite && paddr == 8'h04;
  a_brg_follow: assert property (wr4 |-> ##2 brg_set_sel_o == $past(pwdata[7], 2))
    else $error("baud set select wrong");
  a_mode_follow: assert property (wr4 |-> ##2 ct_timer_mode_o == $past(pwdata[6], 2))
    else $error("timer mode wrong");
  a_sq_counter: assert property (!ct_timer_mode_o && $past(!ct_timer_mode_o) |-> !ct_square_wave_o)
    else $error("square wave in counter mode");
  a_ready_one: assert property (psel && !penable |=> pready)
    else $error("ready late");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_unmapped: assert property (pready && !(paddr inside {8'h04, 8'h14, 8'h18, 8'h1c}) |-> pslverr)
    else $error("unmapped not refused");
  a_err_shared: assert property (pready && paddr == 8'h04 |-> !pslverr)
    else $error("shared address refused");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_irq_reset: assert property ($rose(reset_n_i) |-> interrupt_out_n_o)
    else $error("interrupt after reset");
  a_err_single: assert property (pslverr |-> pready)
    else $error("error outside ready");
endmodule // acic_top_monitor
bind acic_top acic_top_monitor acic_top_monitor_inst (.*);

// ---- acic_src_model.sv ----
// clock source model for the counter/timer inputs
`timescale 1ns/1ps
module acic_src_model (
  input  wire logic sys_clk_i,
  input  wire logic run_i,
  output logic      src_o
);
  initial src_o = 1'b0;
  // toggles each cycle while running, stands still low otherwise
  always @(posedge sys_clk_i) src_o <= run_i && !src_o;
endmodule // acic_src_model

// ---- tb_acic_top.sv ----
// self-checking bench for the aux control block
`timescale 1ns/1ps
module tb_acic_top;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0001_2f7f, prdata, rdv;
  logic [3:0]  gp = 4'h0;
  logic [6:0]  oth = 7'h00;
  logic        pready, pslverr, baud_rate_generator, tmode, tick, sq, irq_n, src, err;
  int          failures = 0, n_compared = 0, en, lvl, dl, sm, x, ticks, tog;
  wire logic [3:0] pins = run ? {gp[3], src, gp[1:0]} : gp;
  acic_top acic_top_inst (.sys_clk_i(clk), .reset_n_i(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gp_input_i(pins), .chan_a_tx_clock_i(src), .chan_b_tx_clock_i(src),
    .main_clock_input_i(src), .other_status_i(oth), .brg_set_sel_o(baud_rate_generator),
    .ct_timer_mode_o(tmode), .ct_tick_o(tick), .ct_square_wave_o(sq),
    .interrupt_out_n_o(irq_n));
  acic_src_model acic_src_model_inst (.sys_clk_i(clk), .run_i(run), .src_o(src));
  initial forever #2 clk = ~clk;
  // xorshift source of pin values
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, idle cycle first so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (k >= 20) failures++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv, exp);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    cyc(6000);
    failures++;
    results();
  end
  initial begin
    cyc(3);
    rst_n <= 1'b1;
    // reset values and a refused place
    rd(8'h18, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test 1 done");
    // random pin changes against the flag model
    en = 3;
    apb(1'b1, 8'h04, 32'h0000_0083);
    apb(1'b1, 8'h18, 32'h0000_0080);
    {lvl, dl, sm} = 0;
    for (int i = 0; i < 12; i++) begin
      x = rnd() & 15;
      gp <= x[3:0];
      cyc(8);
      dl |= lvl ^ x;
      sm |= ((lvl ^ x) & en) != 0;
      lvl = x;
      chk({31'h0, irq_n}, !sm);
      if (i % 2) begin
        rd(8'h14, sm << 7);
        rd(8'h04, dl << 4 | lvl);
        {dl, sm} = 0;
        rd(8'h14, 32'h0000_0000);
      end
    end
    $display("test 2 done");
    // other status bits and their mask
    oth <= 7'h01;
    cyc(4);
    rd(8'h14, 32'h0000_0001);
    chk({31'h0, irq_n}, 32'h0000_0001);
    apb(1'b1, 8'h18, 32'h0000_0081);
    cyc(3);
    chk({31'h0, irq_n}, 32'h0000_0000);
    oth <= 7'h00;
    $display("test 3 done");
    // every counter/timer code with its source running
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, 8'h04, (m << 4) | ((m & 1) << 7));
      {ticks, tog} = 0;
      run <= 1'b1;
      repeat (80) begin
        @(posedge clk);
        ticks += (tick === 1'b1);
        tog += (sq === 1'b1);
      end
      run <= 1'b0;
      chk({31'h0, tmode}, m >> 2);
      chk({31'h0, baud_rate_generator}, m & 1);
      chk(tog > 0, m >> 2);
      chk(ticks > 0, m < 4);
      cyc(4);
    end
    $display("test 4 done");
    results();
  end
endmodule // tb_acic_top
